// >>> core/rox_pkg.sv
package rox_pkg;

  // Pointer and list geometry
  localparam int          ROX_PTR_W    = 32;
  localparam int          ROX_LIST_D   = 4;
  localparam int          ROX_CNT_W    = 3;
  localparam int          ROX_IDX_W    = 2;

  // Values after reset and special codes
  localparam logic [31:0] ROX_NO_BUF   = 32'hFFFFFFFF;
  localparam logic [31:0] ROX_PTR_RST  = 32'h00000000;
  localparam logic [2:0]  ROX_CNT_RST  = 3'h0;
  localparam logic [1:0]  ROX_IDX_RST  = 2'h0;
  localparam logic [2:0]  ROX_CNT_FULL = 3'h4;

  typedef enum logic [2:0] {
    ROX_TX_MEM_WR,
    ROX_TX_MEM_RD,
    ROX_TX_SPLIT_WR,
    ROX_TX_SPLIT_CPL,
    ROX_TX_OTHER
  } rox_kind_t;

  typedef enum logic [2:0] {
    ROX_TGT_PAYLOAD,
    ROX_TGT_CONTROL,
    ROX_TGT_MSG_DATA,
    ROX_TGT_IN_POST,
    ROX_TGT_OUT_POST
  } rox_target_t;

  typedef enum logic [1:0] {
    ROX_MODE_PUSH,
    ROX_MODE_PULL,
    ROX_MODE_OUT_OPT,
    ROX_MODE_PEER
  } rox_mode_t;

endpackage

// >>> core/rox_ptr_list.sv
`timescale 1ns/1ps
`default_nettype none

module rox_ptr_list (
  // Clock and reset
  input  wire logic                          mclk_in,
  input  wire logic                          rst_b_in,
  // Fill side
  input  wire logic                          push_in,
  input  wire logic [rox_pkg::ROX_PTR_W-1:0] push_ptr_in,
  // Drain side
  input  wire logic                          pop_in,
  output logic      [rox_pkg::ROX_PTR_W-1:0] head_ptr_out,
  output logic                               empty_out,
  output logic                               full_out
);
  import rox_pkg::*;

  typedef struct packed {
    logic [ROX_LIST_D-1:0][ROX_PTR_W-1:0] mem;
    logic [ROX_IDX_W-1:0]                 wr_idx;
    logic [ROX_IDX_W-1:0]                 rd_idx;
    logic [ROX_CNT_W-1:0]                 count;
  } rox_list_st_t;

  rox_list_st_t st_q;
  rox_list_st_t st_d;
  logic         do_push;
  logic         do_pop;

  assign empty_out    = (st_q.count == ROX_CNT_RST);
  assign full_out     = (st_q.count == ROX_CNT_FULL);
  assign head_ptr_out = st_q.mem[st_q.rd_idx];
  assign do_pop       = pop_in && !empty_out;
  assign do_push      = push_in && (!full_out || do_pop);

  always_comb begin
    st_d = st_q;
    if (do_push) begin
      st_d.mem[st_q.wr_idx] = push_ptr_in;
      st_d.wr_idx           = st_q.wr_idx + 2'h1;
    end
    if (do_pop) begin
      st_d.rd_idx = st_q.rd_idx + 2'h1;
    end
    case ({do_push, do_pop})
      2'h2:    st_d.count = st_q.count + 3'h1;
      2'h1:    st_d.count = st_q.count - 3'h1;
      default: st_d.count = st_q.count;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q.mem    <= '0;
      st_q.wr_idx <= ROX_IDX_RST;
      st_q.rd_idx <= ROX_IDX_RST;
      st_q.count  <= ROX_CNT_RST;
    end else begin
      st_q <= st_d;
    end
  end

endmodule

`default_nettype wire

// >>> core/rox_attr_select.sv
`timescale 1ns/1ps
`default_nettype none

module rox_attr_select (
  // Clock and reset
  input  wire logic                          mclk_in,
  input  wire logic                          rst_b_in,
  // Configuration
  input  wire logic                          ro_enable_in,
  input  wire rox_pkg::rox_mode_t            mode_in,
  input  wire logic                          host_bridge_in,
  input  wire logic                          colocated_in,
  input  wire logic                          model_relaxed_in,
  input  wire logic                          msg_sync_in,
  // Transaction request
  input  wire logic                          req_valid_in,
  input  wire rox_pkg::rox_kind_t            req_kind_in,
  input  wire rox_pkg::rox_target_t          req_target_in,
  input  wire logic                          cpu_hint_valid_in,
  input  wire logic                          cpu_hint_ro_in,
  input  wire logic                          cpl_req_ro_in,
  // Transaction issue
  output logic                               tx_valid_out,
  output rox_pkg::rox_kind_t                 tx_kind_out,
  output logic                               attr_ro_out,
  // Host queue access
  input  wire logic                          host_ifl_rd_in,
  input  wire logic                          host_ipq_wr_in,
  input  wire logic [rox_pkg::ROX_PTR_W-1:0] host_ipq_ptr_in,
  input  wire logic                          host_opq_rd_in,
  output logic      [rox_pkg::ROX_PTR_W-1:0] host_rdata_out,
  output logic                               host_irq_out,
  // Local processor queue access
  input  wire logic                          lp_ifl_ret_in,
  input  wire logic [rox_pkg::ROX_PTR_W-1:0] lp_ifl_ptr_in,
  input  wire logic                          lp_opq_wr_in,
  input  wire logic [rox_pkg::ROX_PTR_W-1:0] lp_opq_ptr_in,
  output logic                               lp_notify_out,
  output logic      [rox_pkg::ROX_PTR_W-1:0] lp_work_ptr_out
);
  import rox_pkg::*;

  typedef struct packed {
    logic                 tx_valid;
    rox_kind_t            tx_kind;
    logic                 attr_ro;
    logic [ROX_PTR_W-1:0] host_rdata;
    logic                 host_irq;
    logic                 lp_notify;
    logic [ROX_PTR_W-1:0] lp_work_ptr;
  } rox_st_t;

  rox_st_t              st_q;
  rox_st_t              st_d;
  logic                 want_ro;
  logic [ROX_PTR_W-1:0] ifl_head;
  logic                 ifl_empty;
  logic [ROX_PTR_W-1:0] opq_head;
  logic                 opq_empty;
  logic                 opq_full;
  logic                 is_wr;
  logic                 is_rd;

  ////////////////////////////////////////////////////////////////////////////
  // Pointer lists

  rox_ptr_list u_ifl (
    .mclk_in      (mclk_in),
    .rst_b_in     (rst_b_in),
    .push_in      (lp_ifl_ret_in),
    .push_ptr_in  (lp_ifl_ptr_in),
    .pop_in       (host_ifl_rd_in),
    .head_ptr_out (ifl_head),
    .empty_out    (ifl_empty),
    .full_out     ()
  );

  rox_ptr_list u_opq (
    .mclk_in      (mclk_in),
    .rst_b_in     (rst_b_in),
    .push_in      (lp_opq_wr_in),
    .push_ptr_in  (lp_opq_ptr_in),
    .pop_in       (host_opq_rd_in),
    .head_ptr_out (opq_head),
    .empty_out    (opq_empty),
    .full_out     (opq_full)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Attribute decision

  assign is_wr = (req_kind_in == ROX_TX_MEM_WR) || (req_kind_in == ROX_TX_SPLIT_WR);
  assign is_rd = (req_kind_in == ROX_TX_MEM_RD);

  always_comb begin
    want_ro = 1'b0;
    if (req_kind_in == ROX_TX_SPLIT_CPL) begin
      want_ro = cpl_req_ro_in;
    end else if (host_bridge_in) begin
      // Host bridge needs the CPU to state ordering needs
      if (cpu_hint_valid_in) begin
        if (req_target_in == ROX_TGT_IN_POST) begin
          want_ro = 1'b0;
        end else if (req_target_in == ROX_TGT_MSG_DATA && is_wr &&
                     mode_in != ROX_MODE_PULL) begin
          want_ro = 1'b1;
        end else begin
          want_ro = cpu_hint_ro_in;
        end
      end
    end else begin
      // Classification of the transaction drives the choice
      case (req_target_in)
        ROX_TGT_PAYLOAD: begin
          want_ro = 1'b1;
        end
        ROX_TGT_CONTROL: begin
          if (is_rd) begin
            want_ro = colocated_in || model_relaxed_in;
          end else begin
            want_ro = 1'b0;
          end
        end
        ROX_TGT_MSG_DATA: begin
          if (is_rd) begin
            want_ro = (mode_in == ROX_MODE_PULL) || model_relaxed_in;
          end else begin
            case (mode_in)
              ROX_MODE_OUT_OPT: want_ro = 1'b1;
              ROX_MODE_PEER:    want_ro = 1'b1;
              default:          want_ro = msg_sync_in || model_relaxed_in;
            endcase
          end
        end
        ROX_TGT_IN_POST: begin
          want_ro = 1'b0;
        end
        ROX_TGT_OUT_POST: begin
          want_ro = 1'b0;
        end
        default: begin
          want_ro = model_relaxed_in;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_d           = st_q;
    st_d.tx_valid  = req_valid_in;
    st_d.lp_notify = 1'b0;
    if (req_valid_in) begin
      st_d.tx_kind = req_kind_in;
      // Split writes carry the bit but nothing here orders on it
      st_d.attr_ro = want_ro && (ro_enable_in || req_kind_in == ROX_TX_SPLIT_CPL);
    end else begin
      st_d.attr_ro = 1'b0;
    end
    if (host_ifl_rd_in) begin
      st_d.host_rdata = ifl_empty ? ROX_NO_BUF : ifl_head;
    end else if (host_opq_rd_in) begin
      st_d.host_rdata = opq_empty ? ROX_NO_BUF : opq_head;
    end
    if (host_ipq_wr_in) begin
      st_d.lp_notify   = 1'b1;
      st_d.lp_work_ptr = host_ipq_ptr_in;
    end
    // Interrupt stays up while any filled buffer waits for the host
    st_d.host_irq = !opq_empty || (lp_opq_wr_in && !opq_full);
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q.tx_valid    <= 1'b0;
      st_q.tx_kind     <= ROX_TX_OTHER;
      st_q.attr_ro     <= 1'b0;
      st_q.host_rdata  <= ROX_PTR_RST;
      st_q.host_irq    <= 1'b0;
      st_q.lp_notify   <= 1'b0;
      st_q.lp_work_ptr <= ROX_PTR_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign tx_valid_out    = st_q.tx_valid;
  assign tx_kind_out     = st_q.tx_kind;
  assign attr_ro_out     = st_q.attr_ro;
  assign host_rdata_out  = st_q.host_rdata;
  assign host_irq_out    = st_q.host_irq;
  assign lp_notify_out   = st_q.lp_notify;
  assign lp_work_ptr_out = st_q.lp_work_ptr;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);

  enable_gate_a: assert property (req_valid_in && !ro_enable_in &&
    req_kind_in != ROX_TX_SPLIT_CPL |=> tx_valid_out && !attr_ro_out)
    else $error("attribute set while enable clear");
  echo_cpl_a: assert property (req_valid_in && req_kind_in == ROX_TX_SPLIT_CPL
    |=> attr_ro_out == $past(cpl_req_ro_in))
    else $error("completion attribute not echoed");
  ctrl_write_a: assert property (req_valid_in && !host_bridge_in &&
    req_target_in == ROX_TGT_CONTROL && req_kind_in == ROX_TX_MEM_WR |=> !attr_ro_out)
    else $error("control write relaxed");
  ctrl_read_a: assert property (req_valid_in && ro_enable_in && !host_bridge_in &&
    colocated_in && req_target_in == ROX_TGT_CONTROL && req_kind_in == ROX_TX_MEM_RD
    |=> attr_ro_out)
    else $error("co-located control read not relaxed");
  post_strict_a: assert property (req_valid_in && (req_target_in == ROX_TGT_IN_POST ||
    (req_target_in == ROX_TGT_OUT_POST && !host_bridge_in)) &&
    req_kind_in == ROX_TX_MEM_WR |=> !attr_ro_out)
    else $error("posting queue write relaxed");
  host_hint_a: assert property (req_valid_in && host_bridge_in && !cpu_hint_valid_in &&
    req_kind_in != ROX_TX_SPLIT_CPL |=> !attr_ro_out)
    else $error("host bridge relaxed without hint");
  pull_read_a: assert property (req_valid_in && ro_enable_in && !host_bridge_in &&
    mode_in == ROX_MODE_PULL && req_target_in == ROX_TGT_MSG_DATA &&
    req_kind_in == ROX_TX_MEM_RD |=> attr_ro_out)
    else $error("pull message read not relaxed");
  free_empty_a: assert property (host_ifl_rd_in && ifl_empty
    |=> host_rdata_out == ROX_NO_BUF)
    else $error("empty free list gave a pointer");
  post_notify_a: assert property (host_ipq_wr_in
    |=> lp_notify_out && lp_work_ptr_out == $past(host_ipq_ptr_in))
    else $error("inbound post not notified");
  out_irq_a: assert property (lp_opq_wr_in && opq_empty && !host_opq_rd_in
    |=> host_irq_out ##1 host_irq_out)
    else $error("outbound post raised no interrupt");

  relaxed_tx_c: cover property (req_valid_in ##1 tx_valid_out && attr_ro_out);
  irq_drain_c:  cover property (host_irq_out ##1 host_opq_rd_in ##2 !host_irq_out);
  buf_loop_c:   cover property (host_ifl_rd_in && !ifl_empty ##[1:8] host_ipq_wr_in);

endmodule

`default_nettype wire

// >>> verification/rox_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module rox_host_model (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_b_in,
  // Queue side
  input  wire logic        drain_en_in,
  input  wire logic        irq_in,
  input  wire logic [31:0] rdata_in,
  output logic             opq_rd_out,
  output logic      [31:0] got_ptr_out
);
  logic pend_q;

  // Drain outbound entries one at a time while the interrupt is up, held off while disabled
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      opq_rd_out  <= 1'b0;
      pend_q      <= 1'b0;
      got_ptr_out <= 32'h00000000;
    end else begin
      opq_rd_out <= 1'b0;
      pend_q     <= opq_rd_out;
      if (pend_q) begin
        got_ptr_out <= rdata_in;
      end
      if (irq_in && drain_en_in && !opq_rd_out && !pend_q) begin
        opq_rd_out <= 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import rox_pkg::*;

  logic        mclk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        ro_enable_in = 1'b0, host_bridge_in = 1'b0, colocated_in = 1'b0;
  logic        model_relaxed_in = 1'b0, msg_sync_in = 1'b0, req_valid_in = 1'b0;
  logic        cpu_hint_valid_in = 1'b0, cpu_hint_ro_in = 1'b0, cpl_req_ro_in = 1'b0;
  logic        host_ifl_rd_in = 1'b0, host_ipq_wr_in = 1'b0, lp_ifl_ret_in = 1'b0;
  logic        lp_opq_wr_in = 1'b0, drain_en = 1'b0;
  logic [31:0] host_ipq_ptr_in = 32'h0, lp_ifl_ptr_in = 32'h0, lp_opq_ptr_in = 32'h0;
  rox_mode_t   mode_in = ROX_MODE_PUSH;
  rox_kind_t   req_kind_in = ROX_TX_OTHER;
  rox_target_t req_target_in = ROX_TGT_PAYLOAD;
  logic        host_opq_rd_in, tx_valid_out, attr_ro_out, host_irq_out, lp_notify_out;
  rox_kind_t   tx_kind_out;
  logic [31:0] host_rdata_out, lp_work_ptr_out, got_ptr;
  int          failures = 0;
  int          checks = 0;

  always #12.5 mclk_in = ~mclk_in;

  rox_attr_select rox_attr_select_inst (.*);

  rox_host_model rox_host_model_inst (
    .mclk_in     (mclk_in),
    .rst_b_in    (rst_b_in),
    .drain_en_in (drain_en),
    .irq_in      (host_irq_out),
    .rdata_in    (host_rdata_out),
    .opq_rd_out  (host_opq_rd_in),
    .got_ptr_out (got_ptr)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic step;
    @(posedge mclk_in);
    #1;
  endtask

  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t bit got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t word got %h exp %h", $time, got, exp);
    end
  endtask

  // One request, issue checked, then one idle cycle before the next
  task automatic req(input rox_kind_t k, input rox_target_t t, input logic exp);
    req_valid_in = 1'b1;
    req_kind_in = k;
    req_target_in = t;
    step();
    req_valid_in = 1'b0;
    chk1(tx_valid_out, 1'b1);
    chk1(tx_kind_out === k, 1'b1);
    chk1(attr_ro_out, exp);
    step();
    chk1(tx_valid_out, 1'b0);
    chk1(attr_ro_out, 1'b0);
  endtask

  task automatic t_class;
    ro_enable_in = 1'b0;
    colocated_in = 1'b1;
    model_relaxed_in = 1'b1;
    req(ROX_TX_MEM_WR, ROX_TGT_PAYLOAD, 1'b0);
    req(ROX_TX_MEM_RD, ROX_TGT_CONTROL, 1'b0);
    ro_enable_in = 1'b1;
    model_relaxed_in = 1'b0;
    req(ROX_TX_MEM_RD, ROX_TGT_CONTROL, 1'b1);
    req(ROX_TX_MEM_WR, ROX_TGT_CONTROL, 1'b0);
    colocated_in = 1'b0;
    req(ROX_TX_MEM_RD, ROX_TGT_CONTROL, 1'b0);
    model_relaxed_in = 1'b1;
    req(ROX_TX_MEM_RD, ROX_TGT_CONTROL, 1'b1);
    model_relaxed_in = 1'b0;
    step();
    chk1(tx_valid_out, 1'b0);
    chk1(attr_ro_out, 1'b0);
  endtask

  // Back to back: payload then control
  task automatic t_back;
    req_valid_in = 1'b1;
    req_kind_in = ROX_TX_MEM_WR;
    req_target_in = ROX_TGT_PAYLOAD;
    step();
    req_target_in = ROX_TGT_CONTROL;
    chk1(attr_ro_out, 1'b1);
    step();
    req_valid_in = 1'b0;
    chk1(tx_valid_out, 1'b1);
    chk1(attr_ro_out, 1'b0);
    step();
    chk1(tx_valid_out, 1'b0);
  endtask

  task automatic t_modes;
    mode_in = ROX_MODE_PUSH;
    req(ROX_TX_MEM_WR, ROX_TGT_MSG_DATA, 1'b0);
    msg_sync_in = 1'b1;
    req(ROX_TX_MEM_WR, ROX_TGT_MSG_DATA, 1'b1);
    msg_sync_in = 1'b0;
    mode_in = ROX_MODE_PULL;
    req(ROX_TX_MEM_RD, ROX_TGT_MSG_DATA, 1'b1);
    req(ROX_TX_MEM_WR, ROX_TGT_MSG_DATA, 1'b0);
    mode_in = ROX_MODE_OUT_OPT;
    req(ROX_TX_MEM_WR, ROX_TGT_MSG_DATA, 1'b1);
    req(ROX_TX_MEM_WR, ROX_TGT_OUT_POST, 1'b0);
    mode_in = ROX_MODE_PEER;
    req(ROX_TX_MEM_WR, ROX_TGT_MSG_DATA, 1'b1);
    req(ROX_TX_MEM_WR, ROX_TGT_IN_POST, 1'b0);
  endtask

  task automatic t_host;
    host_bridge_in = 1'b1;
    mode_in = ROX_MODE_PUSH;
    cpu_hint_ro_in = 1'b1;
    req(ROX_TX_MEM_WR, ROX_TGT_MSG_DATA, 1'b0);
    cpu_hint_valid_in = 1'b1;
    req(ROX_TX_MEM_WR, ROX_TGT_MSG_DATA, 1'b1);
    req(ROX_TX_MEM_WR, ROX_TGT_IN_POST, 1'b0);
    req(ROX_TX_MEM_RD, ROX_TGT_CONTROL, 1'b1);
    cpu_hint_ro_in = 1'b0;
    req(ROX_TX_MEM_RD, ROX_TGT_CONTROL, 1'b0);
    host_bridge_in = 1'b0;
    cpu_hint_valid_in = 1'b0;
  endtask

  task automatic t_split;
    ro_enable_in = 1'b0;
    cpl_req_ro_in = 1'b1;
    req(ROX_TX_SPLIT_CPL, ROX_TGT_PAYLOAD, 1'b1);
    cpl_req_ro_in = 1'b0;
    req(ROX_TX_SPLIT_CPL, ROX_TGT_PAYLOAD, 1'b0);
    ro_enable_in = 1'b1;
    req(ROX_TX_SPLIT_WR, ROX_TGT_PAYLOAD, 1'b1);
    req(ROX_TX_SPLIT_WR, ROX_TGT_CONTROL, 1'b0);
  endtask

  task automatic t_queues;
    lp_ifl_ret_in = 1'b1;
    lp_ifl_ptr_in = 32'h00001A00;
    host_ipq_ptr_in = 32'h00002B00;
    lp_opq_ptr_in = 32'h00003C00;
    step();
    lp_ifl_ret_in = 1'b0;
    host_ifl_rd_in = 1'b1;
    step();
    host_ifl_rd_in = 1'b0;
    chk32(host_rdata_out, 32'h00001A00);
    step();
    host_ifl_rd_in = 1'b1;
    step();
    host_ifl_rd_in = 1'b0;
    chk32(host_rdata_out, ROX_NO_BUF);
    host_ipq_wr_in = 1'b1;
    step();
    host_ipq_wr_in = 1'b0;
    chk1(lp_notify_out, 1'b1);
    chk32(lp_work_ptr_out, 32'h00002B00);
    step();
    chk1(lp_notify_out, 1'b0);
    lp_opq_wr_in = 1'b1;
    step();
    lp_opq_wr_in = 1'b0;
    chk1(host_irq_out, 1'b1);
    repeat (3) step();
    chk1(host_irq_out, 1'b1);
    drain_en = 1'b1;
    for (int i = 0; i < 10 && got_ptr !== 32'h00003C00; i++) begin
      step();
    end
    chk32(got_ptr, 32'h00003C00);
    chk1(host_irq_out, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("failures %0d checks %0d", failures, checks);
    if (failures == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #20000;
    failures++;
    conclude();
  end

  initial begin
    repeat (8) @(posedge mclk_in);
    #1;
    rst_b_in = 1'b1;
    step();
    t_class();
    t_back();
    t_modes();
    t_host();
    t_split();
    t_queues();
    conclude();
  end
endmodule

`default_nettype wire
